// ==== hw/board_strap_indicator.sv ====
module board_strap_indicator (
	input  logic                                   clock_in,
	input  logic                                   srst_in,
	input  logic [board_strap_pkg::NODE_ID_WIDTH-1:0] node_id_switch_bank_in,
	input  logic [board_strap_pkg::CONFIG_WIDTH-1:0]  config_switch_bank_in,
	input  logic                                   signal_detect_in,
	input  logic                                   own_packet_returned_in,
	input  logic [board_strap_pkg::ADDR_WIDTH-1:0] addr_in,
	input  logic [board_strap_pkg::DATA_WIDTH-1:0] wr_data_in,
	input  logic                                   wr_strobe_in,
	input  logic                                   rd_strobe_in,
	output logic [board_strap_pkg::DATA_WIDTH-1:0] rd_data_out,
	output logic [board_strap_pkg::NODE_ID_WIDTH-1:0] node_id_out,
	output logic                                   redundant_mode_out,
	output logic                                   low_usage_mode_out,
	output logic [1:0]                             pio_window_out,
	output logic                                   removal0_en_out,
	output logic                                   removal1_en_out,
	output logic                                   factory_image_sel_out,
	output logic                                   settings_valid_out,
	output logic                                   lamp_status_out,
	output logic                                   lamp_signal_detect_out,
	output logic                                   lamp_own_data_out
);

	// ==========================================================================
	// Pin synchronisers and strap capture
	// ==========================================================================
	logic [board_strap_pkg::NODE_ID_WIDTH-1:0] node_sw_sync;
	logic [board_strap_pkg::CONFIG_WIDTH-1:0]  cfg_sw_sync;
	logic                                      light_sync;

	strap_if strap ();

	pin_sync #(
		.WIDTH (board_strap_pkg::NODE_ID_WIDTH)
	) u_node_sync (
		.clock_in (clock_in),
		.srst_in  (srst_in),
		.async_in (node_id_switch_bank_in),
		.sync_out (node_sw_sync)
	);

	pin_sync #(
		.WIDTH (board_strap_pkg::CONFIG_WIDTH)
	) u_cfg_sync (
		.clock_in (clock_in),
		.srst_in  (srst_in),
		.async_in (config_switch_bank_in),
		.sync_out (cfg_sw_sync)
	);

	pin_sync #(
		.WIDTH (1)
	) u_light_sync (
		.clock_in (clock_in),
		.srst_in  (srst_in),
		.async_in (signal_detect_in),
		.sync_out (light_sync)
	);

	strap_capture u_capture (
		.clock_in   (clock_in),
		.srst_in    (srst_in),
		.node_sw_in (node_sw_sync),
		.cfg_sw_in  (cfg_sw_sync),
		.strap      (strap)
	);

	// ==========================================================================
	// State
	// ==========================================================================
	typedef struct packed {
		logic                                   status_lamp;
		logic                                   own_data_lamp;
		logic                                   signal_lamp;
		logic                                   light_lost;
		logic                                   switch_moved;
		board_strap_pkg::settings_t             settings;
		logic                                   settings_valid;
		logic [board_strap_pkg::DATA_WIDTH-1:0] rd_data;
	} top_state_t;

	top_state_t st_reg;
	top_state_t st_next;

	function automatic logic hits(
		input logic [board_strap_pkg::ADDR_WIDTH-1:0] addr,
		input logic [board_strap_pkg::ADDR_WIDTH-1:0] target
	);
		return addr == target;
	endfunction

	// ==========================================================================
	// Next state
	// ==========================================================================
	logic csr_write;
	logic moved_now;
	logic lost_now;

	always_comb begin
		csr_write = wr_strobe_in && hits(addr_in, board_strap_pkg::REG_CTRL_STATUS);
		moved_now = strap.valid
			&& ((cfg_sw_sync != strap.cfg_raw) || (node_sw_sync != strap.node_raw));
		lost_now  = st_reg.signal_lamp && !light_sync;

		st_next = st_reg;

		// Decoded settings pass through one more flop so every output is a
		// register; until capture they hold the shipped defaults.
		st_next.settings       = strap.settings;
		st_next.settings_valid = strap.valid;

		st_next.signal_lamp = light_sync;

		if (csr_write) begin
			st_next.status_lamp = wr_data_in[board_strap_pkg::CSR_STATUS_LAMP_BIT];
		end

		// Write-one-to-clear flags; a new event in the same cycle wins.
		if (csr_write && wr_data_in[board_strap_pkg::CSR_OWN_DATA_BIT]) begin
			st_next.own_data_lamp = 1'b0;
		end
		if (own_packet_returned_in) begin
			st_next.own_data_lamp = 1'b1;
		end

		if (csr_write && wr_data_in[board_strap_pkg::CSR_LIGHT_LOST_BIT]) begin
			st_next.light_lost = 1'b0;
		end
		if (lost_now) begin
			st_next.light_lost = 1'b1;
		end

		// A moved switch is only reported; the captured settings stay put.
		if (csr_write && wr_data_in[board_strap_pkg::CSR_SWITCH_MOVED_BIT]) begin
			st_next.switch_moved = 1'b0;
		end
		if (moved_now) begin
			st_next.switch_moved = 1'b1;
		end

		// Read data stand for exactly the cycle after the strobe.
		st_next.rd_data = '0;
		if (rd_strobe_in) begin
			if (hits(addr_in, board_strap_pkg::REG_CTRL_STATUS)) begin
				st_next.rd_data[board_strap_pkg::CSR_STATUS_LAMP_BIT]   = st_reg.status_lamp;
				st_next.rd_data[board_strap_pkg::CSR_SWITCH_MOVED_BIT]  = st_reg.switch_moved;
				st_next.rd_data[board_strap_pkg::CSR_LIGHT_LOST_BIT]    = st_reg.light_lost;
				st_next.rd_data[board_strap_pkg::CSR_SIGNAL_DETECT_BIT] = st_reg.signal_lamp;
				st_next.rd_data[board_strap_pkg::CSR_OWN_DATA_BIT]      = st_reg.own_data_lamp;
			end else if (hits(addr_in, board_strap_pkg::REG_SETTINGS)) begin
				st_next.rd_data[board_strap_pkg::SETTINGS_WIDTH-1:0] = st_reg.settings;
				st_next.rd_data[board_strap_pkg::SETTINGS_VALID_BIT] = st_reg.settings_valid;
			end else if (hits(addr_in, board_strap_pkg::REG_RAW_SWITCHES)) begin
				st_next.rd_data[board_strap_pkg::CONFIG_WIDTH-1:0] = cfg_sw_sync;
				st_next.rd_data[board_strap_pkg::RAW_NODE_LSB +: board_strap_pkg::NODE_ID_WIDTH] =
					node_sw_sync;
			end
		end
	end

	// ==========================================================================
	// Registers
	// ==========================================================================
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			st_reg.status_lamp    <= board_strap_pkg::STATUS_LAMP_RESET;
			st_reg.own_data_lamp  <= 1'b0;
			st_reg.signal_lamp    <= 1'b0;
			st_reg.light_lost     <= 1'b0;
			st_reg.switch_moved   <= 1'b0;
			st_reg.settings       <= board_strap_pkg::SETTINGS_DEFAULT;
			st_reg.settings_valid <= 1'b0;
			st_reg.rd_data        <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// ==========================================================================
	// Outputs
	// ==========================================================================
	assign rd_data_out            = st_reg.rd_data;
	assign node_id_out            = st_reg.settings.node_id;
	assign redundant_mode_out     = st_reg.settings.redundant;
	assign low_usage_mode_out     = st_reg.settings.low_usage;
	assign pio_window_out         = st_reg.settings.window;
	assign removal0_en_out        = st_reg.settings.removal0_en;
	assign removal1_en_out        = st_reg.settings.removal1_en;
	assign factory_image_sel_out  = st_reg.settings.factory_image;
	assign settings_valid_out     = st_reg.settings_valid;
	assign lamp_status_out        = st_reg.status_lamp;
	assign lamp_signal_detect_out = st_reg.signal_lamp;
	assign lamp_own_data_out      = st_reg.own_data_lamp;

endmodule

// ==== hw/board_strap_pkg.sv ====
package board_strap_pkg;

	// ==========================================================================
	// Switch banks
	// ==========================================================================
	localparam int unsigned NODE_ID_WIDTH = 8;
	localparam int unsigned CONFIG_WIDTH  = 8;

	// Bit index n holds switch position n+1; a set bit means a closed switch.
	localparam int unsigned CFG_REDUNDANT_BIT     = 0;
	localparam int unsigned CFG_LOW_USAGE_BIT     = 1;
	localparam int unsigned CFG_WINDOW_LO_BIT     = 2;
	localparam int unsigned CFG_WINDOW_HI_BIT     = 3;
	localparam int unsigned CFG_REMOVAL0_BIT      = 4;
	localparam int unsigned CFG_REMOVAL1_BIT      = 5;
	localparam int unsigned CFG_RESERVED_BIT      = 6;
	localparam int unsigned CFG_FACTORY_IMAGE_BIT = 7;

	// ==========================================================================
	// Decoded settings
	// ==========================================================================
	typedef enum logic [1:0] {
		WINDOW_FULL = 2'b00,
		WINDOW_64M  = 2'b01,
		WINDOW_16M  = 2'b10,
		WINDOW_2M   = 2'b11
	} pio_window_t;

	localparam int unsigned WINDOW_64M_MBYTES = 64;
	localparam int unsigned WINDOW_16M_MBYTES = 16;
	localparam int unsigned WINDOW_2M_MBYTES  = 2;

	typedef struct packed {
		logic [NODE_ID_WIDTH-1:0] node_id;
		logic                     redundant;
		logic                     low_usage;
		pio_window_t              window;
		logic                     removal0_en;
		logic                     removal1_en;
		logic                     factory_image;
	} settings_t;

	localparam settings_t SETTINGS_DEFAULT = settings_t'(15'h0000);
	localparam int unsigned SETTINGS_WIDTH = 15;

	typedef enum logic {
		CAPTURE_SETTLE = 1'b0,
		CAPTURE_LOCKED = 1'b1
	} capture_state_t;

	// ==========================================================================
	// Timing
	// ==========================================================================
	localparam int unsigned CLOCK_PERIOD_NS = 20;
	localparam int unsigned SETTLE_TIME_NS  = 100;
	localparam int unsigned SETTLE_CYCLES   =
		(SETTLE_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int unsigned SETTLE_CNT_WIDTH = 4;

	// ==========================================================================
	// Register map
	// ==========================================================================
	localparam int unsigned ADDR_WIDTH = 8;
	localparam int unsigned DATA_WIDTH = 32;

	localparam logic [ADDR_WIDTH-1:0] REG_CTRL_STATUS  = 8'h00;
	localparam logic [ADDR_WIDTH-1:0] REG_SETTINGS     = 8'h04;
	localparam logic [ADDR_WIDTH-1:0] REG_RAW_SWITCHES = 8'h08;

	localparam int unsigned CSR_STATUS_LAMP_BIT   = 31;
	localparam int unsigned CSR_SWITCH_MOVED_BIT  = 3;
	localparam int unsigned CSR_LIGHT_LOST_BIT    = 2;
	localparam int unsigned CSR_SIGNAL_DETECT_BIT = 1;
	localparam int unsigned CSR_OWN_DATA_BIT      = 0;
	localparam int unsigned SETTINGS_VALID_BIT    = 15;
	localparam int unsigned RAW_NODE_LSB          = 8;

	localparam logic STATUS_LAMP_RESET = 1'b1;

endpackage

// ==== hw/strap_if.sv ====
interface strap_if;
	board_strap_pkg::settings_t                       settings;
	logic                                             valid;
	logic [board_strap_pkg::CONFIG_WIDTH-1:0]         cfg_raw;
	logic [board_strap_pkg::NODE_ID_WIDTH-1:0]        node_raw;

	modport producer (
		output settings,
		output valid,
		output cfg_raw,
		output node_raw
	);

	modport consumer (
		input  settings,
		input  valid,
		input  cfg_raw,
		input  node_raw
	);
endinterface

// ==== hw/pin_sync.sv ====
module pin_sync #(
	parameter int unsigned WIDTH = 1
) (
	input  logic             clock_in,
	input  logic             srst_in,
	input  logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	typedef struct packed {
		logic [WIDTH-1:0] stage1;
		logic [WIDTH-1:0] stage2;
		logic [WIDTH-1:0] stage3;
		logic [WIDTH-1:0] level;
	} sync_state_t;

	sync_state_t st_reg;
	sync_state_t st_next;

	// A bit takes its new level only once stages two and three agree, so a
	// bouncing contact never shows a one-cycle glitch downstream.
	always_comb begin
		st_next        = st_reg;
		st_next.stage1 = async_in;
		st_next.stage2 = st_reg.stage1;
		st_next.stage3 = st_reg.stage2;
		st_next.level  = (st_reg.stage2 & ~(st_reg.stage2 ^ st_reg.stage3))
			| (st_reg.level & (st_reg.stage2 ^ st_reg.stage3));
	end

	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign sync_out = st_reg.level;

endmodule

// ==== hw/strap_capture.sv ====
module strap_capture (
	input  logic                                      clock_in,
	input  logic                                      srst_in,
	input  logic [board_strap_pkg::NODE_ID_WIDTH-1:0] node_sw_in,
	input  logic [board_strap_pkg::CONFIG_WIDTH-1:0]  cfg_sw_in,
	strap_if.producer                                 strap
);

	typedef struct packed {
		board_strap_pkg::capture_state_t                   state;
		logic [board_strap_pkg::SETTLE_CNT_WIDTH-1:0]      count;
		board_strap_pkg::settings_t                        settings;
		logic [board_strap_pkg::CONFIG_WIDTH-1:0]          cfg_raw;
		logic [board_strap_pkg::NODE_ID_WIDTH-1:0]         node_raw;
	} capture_state_reg_t;

	localparam logic [board_strap_pkg::SETTLE_CNT_WIDTH-1:0] SETTLE_LAST =
		board_strap_pkg::SETTLE_CNT_WIDTH'(board_strap_pkg::SETTLE_CYCLES - 1);

	capture_state_reg_t st_reg;
	capture_state_reg_t st_next;

	function automatic board_strap_pkg::settings_t decode_switches(
		input logic [board_strap_pkg::NODE_ID_WIDTH-1:0] node,
		input logic [board_strap_pkg::CONFIG_WIDTH-1:0]  cfg
	);
		board_strap_pkg::settings_t s;
		s               = board_strap_pkg::SETTINGS_DEFAULT;
		s.node_id       = node;
		s.redundant     = cfg[board_strap_pkg::CFG_REDUNDANT_BIT];
		s.low_usage     = cfg[board_strap_pkg::CFG_LOW_USAGE_BIT];
		s.removal0_en   = cfg[board_strap_pkg::CFG_REMOVAL0_BIT];
		s.removal1_en   = cfg[board_strap_pkg::CFG_REMOVAL1_BIT];
		s.factory_image = cfg[board_strap_pkg::CFG_FACTORY_IMAGE_BIT];
		// The reserved position is deliberately left out of every field.
		case ({cfg[board_strap_pkg::CFG_WINDOW_HI_BIT], cfg[board_strap_pkg::CFG_WINDOW_LO_BIT]})
			2'b00: begin
				s.window = board_strap_pkg::WINDOW_FULL;
			end
			2'b01: begin
				s.window = board_strap_pkg::WINDOW_64M;
			end
			2'b10: begin
				s.window = board_strap_pkg::WINDOW_16M;
			end
			default: begin
				s.window = board_strap_pkg::WINDOW_2M;
			end
		endcase
		return s;
	endfunction

	// The synchronisers are cleared by reset, so the pins only become visible
	// a few cycles after release; the settle count covers that latency.
	always_comb begin
		st_next = st_reg;
		case (st_reg.state)
			board_strap_pkg::CAPTURE_SETTLE: begin
				if (st_reg.count == SETTLE_LAST) begin
					st_next.state    = board_strap_pkg::CAPTURE_LOCKED;
					st_next.settings = decode_switches(node_sw_in, cfg_sw_in);
					st_next.cfg_raw  = cfg_sw_in;
					st_next.node_raw = node_sw_in;
				end else begin
					st_next.count = st_reg.count + 1'b1;
				end
			end
			board_strap_pkg::CAPTURE_LOCKED: begin
				// Held until the next reset whatever the switches do.
				st_next = st_reg;
			end
			default: begin
				st_next.state = board_strap_pkg::CAPTURE_SETTLE;
			end
		endcase
	end

	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			st_reg.state    <= board_strap_pkg::CAPTURE_SETTLE;
			st_reg.count    <= '0;
			st_reg.settings <= board_strap_pkg::SETTINGS_DEFAULT;
			st_reg.cfg_raw  <= '0;
			st_reg.node_raw <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign strap.settings = st_reg.settings;
	assign strap.valid    = (st_reg.state == board_strap_pkg::CAPTURE_LOCKED);
	assign strap.cfg_raw  = st_reg.cfg_raw;
	assign strap.node_raw = st_reg.node_raw;

endmodule

// ==== verification/board_strap_monitor.sv ====
module board_strap_monitor (
	input logic        clock_in,
	input logic        srst_in,
	input logic [7:0]  node_id_switch_bank_in,
	input logic [7:0]  config_switch_bank_in,
	input logic        signal_detect_in,
	input logic        own_packet_returned_in,
	input logic [7:0]  addr_in,
	input logic [31:0] wr_data_in,
	input logic        wr_strobe_in,
	input logic        rd_strobe_in,
	input logic [31:0] rd_data_out,
	input logic [7:0]  node_id_out,
	input logic        redundant_mode_out,
	input logic        low_usage_mode_out,
	input logic [1:0]  pio_window_out,
	input logic        removal0_en_out,
	input logic        removal1_en_out,
	input logic        factory_image_sel_out,
	input logic        settings_valid_out,
	input logic        lamp_status_out,
	input logic        lamp_signal_detect_out,
	input logic        lamp_own_data_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================================
	// Properties
	// ==========================================================================
	default clocking @(posedge clock_in); endclocking
	default disable iff (srst_in);
	wire [14:0] s = {node_id_out, redundant_mode_out, low_usage_mode_out, pio_window_out,
		removal0_en_out, removal1_en_out, factory_image_sel_out};
	wire [7:0]  c = config_switch_bank_in;
	property p_decode;
		$rose(settings_valid_out) |-> s == {node_id_switch_bank_in, c[0], c[1], c[3], c[2],
			c[4], c[5], c[7]};
	endproperty
	a_decode: assert property (p_decode) else $error("decoded settings wrong");
	property p_default;
		!settings_valid_out |-> s == 15'h0000;
	endproperty
	a_default: assert property (p_default) else $error("defaults not shown");
	property p_valid_time;
		$fell(srst_in) |-> ##[4:8] settings_valid_out;
	endproperty
	a_valid_time: assert property (p_valid_time) else $error("capture late");
	property p_hold;
		settings_valid_out |=> settings_valid_out && $stable(s);
	endproperty
	a_hold: assert property (p_hold) else $error("settings moved");
	property p_reset_lamps;
		$fell(srst_in) |-> lamp_status_out && !lamp_own_data_out;
	endproperty
	a_reset_lamps: assert property (p_reset_lamps) else $error("lamp reset wrong");
	property p_status_wr;
		wr_strobe_in && addr_in == 8'h00 |=> lamp_status_out == $past(wr_data_in[31]);
	endproperty
	a_status_wr: assert property (p_status_wr) else $error("status lamp write");
	property p_status_rd;
		rd_strobe_in && addr_in == 8'h00 |=> rd_data_out[31] == $past(lamp_status_out);
	endproperty
	a_status_rd: assert property (p_status_rd) else $error("status readback");
	property p_light_on;
		signal_detect_in [*6] |=> lamp_signal_detect_out;
	endproperty
	a_light_on: assert property (p_light_on) else $error("signal lamp dark");
	property p_light_off;
		(!signal_detect_in) [*6] |=> !lamp_signal_detect_out;
	endproperty
	a_light_off: assert property (p_light_off) else $error("signal lamp lit");
	property p_own;
		own_packet_returned_in |=> lamp_own_data_out;
	endproperty
	a_own: assert property (p_own) else $error("own data lamp dark");
	c_valid: cover property ($rose(settings_valid_out));
	c_own: cover property ($rose(lamp_own_data_out));
	c_light: cover property ($rose(lamp_signal_detect_out));
	c_status: cover property ($fell(lamp_status_out));
endmodule

bind board_strap_indicator board_strap_monitor i_mon (.clock_in, .srst_in,
	.node_id_switch_bank_in, .config_switch_bank_in, .signal_detect_in,
	.own_packet_returned_in, .addr_in, .wr_data_in, .wr_strobe_in, .rd_strobe_in, .rd_data_out,
	.node_id_out, .redundant_mode_out, .low_usage_mode_out, .pio_window_out, .removal0_en_out,
	.removal1_en_out, .factory_image_sel_out, .settings_valid_out, .lamp_status_out,
	.lamp_signal_detect_out, .lamp_own_data_out);

// ==== verification/switch_panel_model.sv ====
module switch_panel_model (
	input  logic [7:0] node_set_in,
	input  logic [7:0] cfg_set_in,
	input  logic       light_set_in,
	output logic [7:0] node_sw_out,
	output logic [7:0] cfg_sw_out,
	output logic       light_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// The installer never closes the reserved position, whatever is asked for.
	assign cfg_sw_out  = cfg_set_in & 8'hbf;
	assign node_sw_out = node_set_in;
	assign light_out   = light_set_in;
endmodule

// ==== verification/board_strap_indicator_tb_top.sv ====
module board_strap_indicator_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clock_in = 1'b0;
	logic        srst_in = 1'b1;
	logic [7:0]  node_req = 8'h00;
	logic [7:0]  cfg_req = 8'h00;
	logic        light_req = 1'b0;
	logic [7:0]  node_id_switch_bank_in;
	logic [7:0]  config_switch_bank_in;
	logic        signal_detect_in;
	logic        own_packet_returned_in = 1'b0;
	logic [7:0]  addr_in = 8'h00;
	logic [31:0] wr_data_in = 32'h0;
	logic        wr_strobe_in = 1'b0;
	logic        rd_strobe_in = 1'b0;
	logic [31:0] rd_data_out;
	logic [7:0]  node_id_out;
	logic        redundant_mode_out, low_usage_mode_out, removal0_en_out, removal1_en_out;
	logic [1:0]  pio_window_out;
	logic        factory_image_sel_out, settings_valid_out;
	logic        lamp_status_out, lamp_signal_detect_out, lamp_own_data_out;
	int          mismatches = 0;
	int          check_count = 0;

	always #10 clock_in = ~clock_in;

	switch_panel_model i_panel (.node_set_in(node_req), .cfg_set_in(cfg_req),
		.light_set_in(light_req), .node_sw_out(node_id_switch_bank_in),
		.cfg_sw_out(config_switch_bank_in), .light_out(signal_detect_in));

	board_strap_indicator i_dut (.clock_in, .srst_in, .node_id_switch_bank_in,
		.config_switch_bank_in, .signal_detect_in, .own_packet_returned_in, .addr_in,
		.wr_data_in, .wr_strobe_in, .rd_strobe_in, .rd_data_out, .node_id_out,
		.redundant_mode_out, .low_usage_mode_out, .pio_window_out, .removal0_en_out,
		.removal1_en_out, .factory_image_sel_out, .settings_valid_out, .lamp_status_out,
		.lamp_signal_detect_out, .lamp_own_data_out);

	// ==========================================================================
	// Helpers
	// ==========================================================================
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Switches only count at power-up, so every new pattern needs a fresh reset.
	task automatic boot(input logic [7:0] n, input logic [7:0] c);
		@(posedge clock_in);
		node_req <= n;
		cfg_req  <= c;
		srst_in  <= 1'b1;
		repeat (2) @(posedge clock_in);
		srst_in <= 1'b0;
		for (int i = 0; i < 20 && settings_valid_out !== 1'b1; i++) @(posedge clock_in);
		#1;
		chk("valid", 32'h1, settings_valid_out);
	endtask

	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_in);
		addr_in      <= a;
		wr_data_in   <= d;
		wr_strobe_in <= 1'b1;
		@(posedge clock_in);
		wr_strobe_in <= 1'b0;
		#1;
	endtask

	task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clock_in);
		addr_in      <= a;
		rd_strobe_in <= 1'b1;
		@(posedge clock_in);
		rd_strobe_in <= 1'b0;
		#1;
		d = rd_data_out;
	endtask

	// ==========================================================================
	// Scenarios
	// ==========================================================================
	task automatic test_straps();
		logic [7:0] n[10] = '{8'h00, 8'h01, 8'h80, 8'hff, 8'h5a, 8'ha5, 8'h00, 8'h00, 8'h00, 8'h3c};
		logic [7:0] c[10] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h20, 8'h80, 8'hff};
		logic [7:0] e;
		for (int i = 0; i < 10; i++) begin
			boot(n[i], c[i]);
			e = c[i] & 8'hbf;
			chk("node_id", n[i], node_id_out);
			chk("redundant", e[0], redundant_mode_out);
			chk("low_usage", e[1], low_usage_mode_out);
			chk("window", {e[3], e[2]}, pio_window_out);
			chk("removal0", e[4], removal0_en_out);
			chk("removal1", e[5], removal1_en_out);
			chk("factory", e[7], factory_image_sel_out);
		end
	endtask

	task automatic test_hold();
		logic [31:0] d;
		boot(8'h12, 8'h21);
		@(posedge clock_in);
		node_req <= 8'hed;
		cfg_req  <= 8'h9e;
		repeat (10) @(posedge clock_in);
		#1;
		chk("held node", 32'h12, node_id_out);
		chk("held redundant", 32'h1, redundant_mode_out);
		chk("held removal1", 32'h1, removal1_en_out);
		chk("held window", 32'h0, pio_window_out);
		bus_rd(8'h04, d);
		chk("settings reg", 32'h8942, d);
		bus_rd(8'h08, d);
		chk("raw switches", 32'hed9e, d);
		bus_rd(8'h00, d);
		chk("switch moved", 32'h8, d & 32'h8);
	endtask

	task automatic test_status_lamp();
		logic [31:0] d;
		boot(8'h00, 8'h00);
		chk("status lamp reset", 32'h1, lamp_status_out);
		chk("node default", 32'h0, node_id_out);
		bus_rd(8'h00, d);
		chk("csr bit31", 32'h1, d[31]);
		@(posedge clock_in);
		#1;
		chk("rd data one cycle", 32'h0, rd_data_out);
		bus_wr(8'h00, 32'h0);
		chk("status lamp off", 32'h0, lamp_status_out);
		bus_rd(8'h00, d);
		chk("csr bit31 off", 32'h0, d[31]);
		bus_wr(8'h00, 32'h80000000);
		chk("status lamp on", 32'h1, lamp_status_out);
		bus_wr(8'h04, 32'hffffffff);
		bus_rd(8'hfc, d);
		chk("unmapped read", 32'h0, d);
		chk("settings after write", 32'h0, node_id_out);
	endtask

	task automatic test_signal_lamp();
		logic [31:0] d;
		@(posedge clock_in);
		light_req <= 1'b1;
		repeat (7) @(posedge clock_in);
		#1;
		chk("signal lamp lit", 32'h1, lamp_signal_detect_out);
		bus_rd(8'h00, d);
		chk("csr signal", 32'h1, d[1]);
		@(posedge clock_in);
		light_req <= 1'b0;
		repeat (7) @(posedge clock_in);
		#1;
		chk("signal lamp dark", 32'h0, lamp_signal_detect_out);
		bus_rd(8'h00, d);
		chk("csr light lost", 32'h4, d & 32'h6);
		bus_wr(8'h00, 32'h80000004);
		bus_rd(8'h00, d);
		chk("csr light lost cleared", 32'h0, d[2]);
	endtask

	task automatic test_own_data();
		logic [31:0] d;
		boot(8'h07, 8'h00);
		chk("own lamp reset", 32'h0, lamp_own_data_out);
		@(posedge clock_in);
		own_packet_returned_in <= 1'b1;
		@(posedge clock_in);
		own_packet_returned_in <= 1'b0;
		#1;
		chk("own lamp lit", 32'h1, lamp_own_data_out);
		repeat (5) @(posedge clock_in);
		#1;
		chk("own lamp stays", 32'h1, lamp_own_data_out);
		bus_rd(8'h00, d);
		chk("csr own bit", 32'h1, d[0]);
		bus_wr(8'h00, 32'h80000001);
		chk("own lamp cleared", 32'h0, lamp_own_data_out);
		// A returning packet in the cycle of the clear must win.
		@(posedge clock_in);
		own_packet_returned_in <= 1'b1;
		addr_in                <= 8'h00;
		wr_data_in             <= 32'h80000001;
		wr_strobe_in           <= 1'b1;
		@(posedge clock_in);
		own_packet_returned_in <= 1'b0;
		wr_strobe_in           <= 1'b0;
		#1;
		chk("own lamp set wins", 32'h1, lamp_own_data_out);
	endtask

	initial begin
		test_straps();
		test_hold();
		test_status_lamp();
		test_signal_lamp();
		test_own_data();
		finish_test();
	end

	initial begin
		#200000;
		mismatches++;
		finish_test();
	end
endmodule
